// ===== bench/wbr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module wbr_host_model (
    input wire logic ref_clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic sclk_o,
    output logic csn_o,
    output logic sdi_o
);
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        sdi_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // Address, direction, then data, each lsb first; sclk halves of 3 cycles
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] data,
        input int nbits, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {data, wr, addr};
        if (wr && addr == 7'h03) frame[15] = ^data[6:0];
        rdata = 8'h00;
        tick(1);
        csn_o = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            sdi_o = frame[k];
            tick(3);
            if (k >= 8) rdata[k-8] = sdo_oe_i ? sdo_i : 1'bx;
            sclk_o = 1'b1;
            tick(3);
            sclk_o = 1'b0;
        end
        tick(3);
        csn_o = 1'b1;
        // Released line flips so a stale level cannot pass for data
        sdi_o = ~sdi_o;
        tick(4);
    endtask
endmodule
`default_nettype wire

// ===== bench/wbr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module wbr_regs_bench;
    import wbr_pkg::*;
    typedef struct packed {
        logic [6:0] addr;
        wbr_mode_t mode;
        logic [7:0] wdata;
        logic [7:0] exp;
    } wbr_row_t;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, csn, sdi, sdo, sdo_oe, spi_fail, int_o, fo, vcfg, ls, ls_stp;
    logic lo, hi, win, bus_en, bus_start, peak, tim_a, tim_b;
    logic [9:0] period;
    logic [1:0] trx;
    logic [2:0] ewk;
    wbr_mode_t mode = WBR_MODE_NORMAL;
    logic soft_reset = 1'b0;
    logic restart = 1'b0;
    logic fail_safe = 1'b0;
    logic bus_wake = 1'b0;
    logic [1:0] trx_cause = 2'h0;
    logic [3:0] wakes = 4'h0;
    logic [7:0] status = 8'h00;
    logic [7:0] shadow [128];
    int n_fail = 0;
    int n_checks = 0;
    int fail_seen = 0;
    int cycles = 0;
    wbr_row_t rows [12] = '{
        '{7'h03, WBR_MODE_NORMAL, 8'h6D, 8'hE5},
        '{7'h03, WBR_MODE_NORMAL, 8'h1F, 8'h95},
        '{7'h04, WBR_MODE_NORMAL, 8'hFD, 8'h01},
        '{7'h04, WBR_MODE_NORMAL, 8'h02, 8'h02},
        '{7'h04, WBR_MODE_NORMAL, 8'h03, 8'h03},
        '{7'h04, WBR_MODE_NORMAL, 8'h00, 8'h00},
        '{7'h05, WBR_MODE_INIT, 8'hFF, 8'h20},
        '{7'h05, WBR_MODE_STOP, 8'h00, 8'h20},
        '{7'h05, WBR_MODE_NORMAL, 8'h00, 8'h00},
        '{7'h06, WBR_MODE_NORMAL, 8'hFF, 8'hC4},
        '{7'h7F, WBR_MODE_NORMAL, 8'hFF, 8'h00},
        '{7'h02, WBR_MODE_NORMAL, 8'hFF, 8'hFB}
    };
    logic [9:0] periods [6] = '{PERIOD_10_MS, PERIOD_20_MS, PERIOD_50_MS, PERIOD_100_MS,
        PERIOD_200_MS, PERIOD_500_MS};

    wbr_host_model host_u (.ref_clk_i(ref_clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .sclk_o(sclk), .csn_o(csn), .sdi_o(sdi));

    wbr_regs dut_u (.ref_clk_i(ref_clk), .resetn_i(resetn), .spi_sclk_i(sclk),
        .spi_csn_i(csn), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .spi_fail_o(spi_fail), .sbc_mode_i(mode), .soft_reset_i(soft_reset),
        .restart_entry_i(restart), .fail_safe_entry_i(fail_safe), .trx_reset_mode_i(trx_cause),
        .bus_wake_i(bus_wake), .wake_events_i(wakes), .status_events_i(status), .int_o(int_o),
        .failure_outputs_o(fo), .aux_regulator_voltage_cfg_o(vcfg),
        .aux_regulator_load_share_o(ls), .load_share_stop_enable_o(ls_stp),
        .wdg_stop_disable_lo_o(lo), .wdg_stop_disable_hi_o(hi), .wdg_window_select_o(win),
        .wdg_start_on_bus_wake_o(bus_en), .wdg_bus_wake_start_o(bus_start),
        .wdg_period_ms_o(period), .transceiver_mode_o(trx), .peak_current_threshold_sel_o(peak),
        .cyclic_timer_a_wake_en_o(tim_a), .cyclic_timer_b_wake_en_o(tim_b), .ext_wake_en_o(ewk));

    ////////////////////////////////////////////////////////////////////////////////
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (spi_fail === 1'b1) fail_seen++;
        cycles++;
        // Ceiling well above the roughly 7000 cycles the sequence needs
        if (cycles == 40000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        host_u.xfer(a, 1'b0, 8'h00, 16, r);
        check({8'h00, r}, {8'h00, exp});
        shadow[a] = exp;
    endtask
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        host_u.xfer(a, 1'b1, d, 16, r);
        check({8'h00, r}, {8'h00, shadow[a]});
        reg_read(a, exp);
    endtask
    // Upper byte: bits of the register that have a port; lower byte: those ports
    function automatic logic [15:0] port_view(input logic [6:0] a);
        case (a)
            7'h02: return {8'hAA, vcfg, 1'b0, fo, 1'b0, ls, 1'b0, ls_stp, 1'b0};
            7'h03: return {8'h70, 1'b0, lo, win, bus_en, 4'h0};
            7'h04: return {8'h03, 6'h00, trx};
            7'h05: return {8'h20, 2'h0, peak, 5'h00};
            7'h06: return {8'hC4, tim_b, tim_a, 3'h0, hi, 2'h0};
            default: return 16'h0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] pv;
        logic [7:0] r;
        int f0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[3] = WDG_RST;
        shadow[7] = EWK_RST;
        repeat (12) @(posedge ref_clk);
        check(16'(period), 16'(PERIOD_200_MS));
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 12; i++) begin
            mode = rows[i].mode;
            reg_write(rows[i].addr, rows[i].wdata, rows[i].exp);
            pv = port_view(rows[i].addr);
            check({8'h00, pv[7:0]}, {8'h00, rows[i].exp & pv[15:8]});
        end
        // Soft reset keeps set aux bits
        trx_cause = 2'h2;
        pulse(soft_reset);
        reg_read(7'h02, 8'h88);
        reg_read(7'h03, 8'h14);
        reg_read(7'h04, 8'h00);
        reg_read(7'h05, 8'h00);
        reg_read(7'h06, 8'h00);
        // Restart with 02, 05 and 06 fully set and 03 at F5 beforehand
        reg_write(7'h02, 8'hFB, 8'hFB);
        check(16'(fo), 16'h0001);
        reg_write(7'h03, 8'h75, 8'hF5);
        reg_write(7'h05, 8'h20, 8'h20);
        reg_write(7'h06, 8'hC4, 8'hC4);
        trx_cause = 2'h3;
        pulse(restart);
        check(16'(fo), 16'h0000);
        reg_read(7'h02, 8'hD9);
        reg_read(7'h03, 8'hB4);
        reg_read(7'h04, 8'h03);
        reg_read(7'h05, 8'h20);
        reg_read(7'h06, 8'hC0);
        // Bus wake in stop, with and without the start bit
        mode = WBR_MODE_STOP;
        bus_wake = 1'b1;
        tick(1);
        check(16'(bus_start), 16'h0001);
        bus_wake = 1'b0;
        mode = WBR_MODE_NORMAL;
        reg_write(7'h03, 8'h04, 8'h84);
        mode = WBR_MODE_STOP;
        bus_wake = 1'b1;
        tick(1);
        check(16'(bus_start), 16'h0000);
        bus_wake = 1'b0;
        mode = WBR_MODE_NORMAL;
        // Fail-safe from all wakes off
        reg_write(7'h07, 8'h00, 8'h00);
        pulse(fail_safe);
        reg_read(7'h04, 8'h01);
        check(16'(ewk), 16'h0007);
        reg_read(7'h07, 8'h07);
        // Interrupt source selection, then period codes 0 to 5
        status = 8'h01;
        tick(1);
        check(16'(int_o), 16'h0000);
        wakes = 4'h1;
        tick(1);
        check(16'(int_o), 16'h0001);
        wakes = 4'h0;
        reg_write(7'h07, 8'h80, 8'h80);
        check(16'(int_o), 16'h0001);
        status = 8'h00;
        for (int c = 0; c < 6; c++) begin
            reg_write(7'h03, 8'(c), {^3'(c), 4'h0, 3'(c)});
            check(16'(period), 16'(periods[c]));
        end
        // Short frame is refused and raises the fail pulse once
        f0 = fail_seen;
        host_u.xfer(7'h03, 1'b1, 8'h00, 12, r);
        check(16'(fail_seen - f0), 16'h0001);
        check(16'(fail_seen), 16'h0001);
        reg_read(7'h03, shadow[3]);
        // Power-on reset in mid-run returns the registers to their reset values
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        reg_read(7'h02, 8'h00);
        reg_read(7'h03, 8'h14);
        finish_test();
    end
endmodule
`default_nettype wire

// ===== design/wbr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module wbr_regs #(
    parameter int WAKE_SRCS = 4,
    parameter int STATUS_BITS = 8
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic spi_sclk_i,
    input wire logic spi_csn_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    output logic spi_fail_o,
    input wire wbr_pkg::wbr_mode_t sbc_mode_i,
    input wire logic soft_reset_i,
    input wire logic restart_entry_i,
    input wire logic fail_safe_entry_i,
    input wire logic [1:0] trx_reset_mode_i,
    input wire logic bus_wake_i,
    input wire logic [WAKE_SRCS-1:0] wake_events_i,
    input wire logic [STATUS_BITS-1:0] status_events_i,
    output logic int_o,
    output logic failure_outputs_o,
    output logic aux_regulator_voltage_cfg_o,
    output logic aux_regulator_load_share_o,
    output logic load_share_stop_enable_o,
    output logic wdg_stop_disable_lo_o,
    output logic wdg_stop_disable_hi_o,
    output logic wdg_window_select_o,
    output logic wdg_start_on_bus_wake_o,
    output logic wdg_bus_wake_start_o,
    output logic [9:0] wdg_period_ms_o,
    output logic [1:0] transceiver_mode_o,
    output logic peak_current_threshold_sel_o,
    output logic cyclic_timer_a_wake_en_o,
    output logic cyclic_timer_b_wake_en_o,
    output logic [2:0] ext_wake_en_o
);
    import wbr_pkg::*;

    logic [7:0] hw_q;
    logic [7:0] wdg_q;
    logic [7:0] trx_q;
    logic [7:0] peak_q;
    logic [7:0] iwk_q;
    logic [7:0] ewk_q;
    logic [9:0] period_q;
    logic bus_start_q;
    logic int_q;
    logic fail_q;

    logic hdr;
    logic frame;
    logic bad_frame;
    logic [6:0] addr;
    logic is_write;
    logic [7:0] wdata;
    logic [7:0] rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Serial frame engine
    wbr_spi_frame u_spi (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .sclk_i(spi_sclk_i),
        .csn_i(spi_csn_i),
        .sdi_i(spi_sdi_i),
        .tx_load_i(hdr),
        .tx_data_i(rd_data),
        .sdo_o(spi_sdo_o),
        .hdr_o(hdr),
        .frame_o(frame),
        .bad_frame_o(bad_frame),
        .addr_o(addr),
        .write_o(is_write),
        .wdata_o(wdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path
    // Sampled at the header, before the write lands at frame end
    assign rd_data =
        (addr == ADDR_HW_CTRL) ? (hw_q & HW_WMASK) :
        (addr == ADDR_WDG_SETUP) ? (wdg_q & WDG_WMASK) :
        (addr == ADDR_TRX_MODE) ? (trx_q & TRX_WMASK) :
        (addr == ADDR_PEAK_TH) ? (peak_q & PEAK_WMASK) :
        (addr == ADDR_IWAKE) ? (iwk_q & IWK_WMASK) :
        (addr == ADDR_EWAKE) ? (ewk_q & EWK_WMASK) : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr = frame && is_write;
    wire wr_hw = wr && (addr == ADDR_HW_CTRL);
    wire wr_wdg = wr && (addr == ADDR_WDG_SETUP);
    wire wr_trx = wr && (addr == ADDR_TRX_MODE);
    wire wr_peak = wr && (addr == ADDR_PEAK_TH);
    wire wr_iwk = wr && (addr == ADDR_IWAKE);
    wire wr_ewk = wr && (addr == ADDR_EWAKE);
    wire in_stop = (sbc_mode_i == WBR_MODE_STOP);
    // Stop mode makes the peak bit read only, with no error raised
    wire peak_ok = (sbc_mode_i == WBR_MODE_INIT) || (sbc_mode_i == WBR_MODE_NORMAL);
    // Reserved codes would leave the watchdog timing undefined
    wire period_ok = (wdata[2:0] <= WDG_PERIOD_LAST);

    wire [7:0] hw_wr = (hw_q & ~HW_WMASK) | (wdata & HW_WMASK);
    wire [7:0] wdg_mix = (wdg_q & ~WDG_WMASK) | (wdata & WDG_WMASK);
    wire [7:0] wdg_wr = period_ok ? wdg_mix : {wdg_mix[7:3], wdg_q[2:0]};
    wire [7:0] trx_wr = (trx_q & ~TRX_WMASK) | (wdata & TRX_WMASK);
    wire [7:0] peak_wr = (peak_q & ~PEAK_WMASK) | (wdata & PEAK_WMASK);
    wire [7:0] iwk_wr = (iwk_q & ~IWK_WMASK) | (wdata & IWK_WMASK);
    wire [7:0] ewk_wr = (ewk_q & ~EWK_WMASK) | (wdata & EWK_WMASK);

    ////////////////////////////////////////////////////////////////////////
    // Register next values: soft reset, restart, fail-safe (trx and ewk only), then write
    wire [7:0] hw_d =
        soft_reset_i ? (hw_q & HW_SOFT_KEEP) :
        restart_entry_i ? (hw_q & HW_RESTART_KEEP) :
        wr_hw ? hw_wr : hw_q;
    wire [7:0] wdg_d =
        soft_reset_i ? WDG_RST :
        restart_entry_i ? ((wdg_q & WDG_RESTART_KEEP) | WDG_RESTART_SET) :
        wr_wdg ? wdg_wr : wdg_q;
    // Soft reset clears the field; only restart follows the cause
    wire [7:0] trx_d =
        soft_reset_i ? TRX_RST :
        restart_entry_i ? {6'h00, trx_reset_mode_i} :
        fail_safe_entry_i ? {6'h00, TRX_WAKE_CAPABLE} :
        wr_trx ? trx_wr : trx_q;
    wire [7:0] peak_d =
        soft_reset_i ? PEAK_RST :
        restart_entry_i ? (peak_q & PEAK_RESTART_KEEP) :
        (wr_peak && peak_ok) ? peak_wr : peak_q;
    wire [7:0] iwk_d =
        soft_reset_i ? IWK_RST :
        restart_entry_i ? (iwk_q & IWK_RESTART_KEEP) :
        wr_iwk ? iwk_wr : iwk_q;
    wire [7:0] ewk_d =
        soft_reset_i ? EWK_RST :
        restart_entry_i ? (ewk_q & EWK_RESTART_KEEP) :
        fail_safe_entry_i ? (ewk_q | EWK_FAILSAFE_SET) :
        wr_ewk ? ewk_wr : ewk_q;

    // Period lookup
    wire [9:0] period_d =
        (wdg_q[2:0] == 3'h0) ? PERIOD_10_MS :
        (wdg_q[2:0] == 3'h1) ? PERIOD_20_MS :
        (wdg_q[2:0] == 3'h2) ? PERIOD_50_MS :
        (wdg_q[2:0] == 3'h3) ? PERIOD_100_MS :
        (wdg_q[2:0] == 3'h4) ? PERIOD_200_MS :
        (wdg_q[2:0] == 3'h5) ? PERIOD_500_MS : period_q;

    wire wake_any = |wake_events_i;
    wire status_any = |status_events_i;
    wire int_d = wake_any || (ewk_q[EWK_INT_GLOBAL_BIT] && status_any);
    wire bus_start_d = bus_wake_i && in_stop && wdg_q[WDG_BUS_WAKE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset clears straight to the documented values
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hw_q <= HW_RST;
            wdg_q <= WDG_RST;
            trx_q <= TRX_RST;
            peak_q <= PEAK_RST;
            iwk_q <= IWK_RST;
            ewk_q <= EWK_RST;
        end else begin
            hw_q <= hw_d;
            wdg_q <= wdg_d;
            trx_q <= trx_d;
            peak_q <= peak_d;
            iwk_q <= iwk_d;
            ewk_q <= ewk_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_q <= PERIOD_200_MS;
            bus_start_q <= 1'b0;
            int_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            period_q <= period_d;
            bus_start_q <= bus_start_d;
            int_q <= int_d;
            // Only malformed frames count as access errors
            fail_q <= bad_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign spi_sdo_oe_o = !spi_csn_i;
    assign spi_fail_o = fail_q;
    assign int_o = int_q;
    assign failure_outputs_o = hw_q[HW_FO_BIT];
    assign aux_regulator_voltage_cfg_o = hw_q[HW_VCFG_BIT];
    assign aux_regulator_load_share_o = hw_q[HW_LS_BIT];
    assign load_share_stop_enable_o = hw_q[HW_LS_STOP_BIT];
    assign wdg_stop_disable_lo_o = wdg_q[WDG_STOP_LO_BIT];
    assign wdg_stop_disable_hi_o = iwk_q[IWK_STOP_HI_BIT];
    assign wdg_window_select_o = wdg_q[WDG_WIN_BIT];
    assign wdg_start_on_bus_wake_o = wdg_q[WDG_BUS_WAKE_BIT];
    assign wdg_bus_wake_start_o = bus_start_q;
    assign wdg_period_ms_o = period_q;
    assign transceiver_mode_o = trx_q[1:0];
    assign peak_current_threshold_sel_o = peak_q[PEAK_BIT];
    assign cyclic_timer_a_wake_en_o = iwk_q[IWK_TIMER_A_BIT];
    assign cyclic_timer_b_wake_en_o = iwk_q[IWK_TIMER_B_BIT];
    assign ext_wake_en_o = ewk_q[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    wire quiet = !soft_reset_i && !restart_entry_i && !fail_safe_entry_i;

    fo_restart_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        restart_entry_i |=> !failure_outputs_o)
        else $error("failure output still active after restart");

    soft_keep_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        soft_reset_i |=> hw_q == ($past(hw_q) & HW_SOFT_KEEP))
        else $error("soft reset did not keep aux regulator bits");

    wdg_reset_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        soft_reset_i |=> wdg_q == WDG_RST)
        else $error("watchdog setup not at reset value");

    wdg_restart_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        restart_entry_i && !soft_reset_i
        |=> wdg_q == (($past(wdg_q) & WDG_RESTART_KEEP) | WDG_RESTART_SET))
        else $error("watchdog setup wrong after restart");

    rsvd_zero_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        hdr |=> (((wdg_q & ~WDG_WMASK) | (trx_q & ~TRX_WMASK)
            | (peak_q & ~PEAK_WMASK) | (iwk_q & ~IWK_WMASK)) == 8'h00))
        else $error("reserved bit held a one");

    period_keep_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_wdg && quiet && (wdata[2:0] > WDG_PERIOD_LAST)
        |=> $stable(wdg_q[2:0]) ##1 (wdg_period_ms_o == $past(wdg_period_ms_o)))
        else $error("reserved period code changed the period");

    period_map_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wdg_q[2:0] == 3'h5) |=> (wdg_period_ms_o == PERIOD_500_MS))
        else $error("period code 101 not mapped to 500 ms");

    peak_stop_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_peak && in_stop && quiet |=> $stable(peak_q) && !spi_fail_o)
        else $error("peak bit written in stop mode");

    peak_restart_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        restart_entry_i && !soft_reset_i
        |=> peak_q == ($past(peak_q) & PEAK_RESTART_KEEP))
        else $error("peak register wrong after restart");

    iwk_restart_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        restart_entry_i && !soft_reset_i
        |=> iwk_q == ($past(iwk_q) & IWK_RESTART_KEEP))
        else $error("internal wake register wrong after restart");

    fail_safe_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        fail_safe_entry_i && !soft_reset_i && !restart_entry_i
        |=> (transceiver_mode_o == TRX_WAKE_CAPABLE) && (ext_wake_en_o == 3'h7))
        else $error("fail-safe did not restore wake sources");

    int_global_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !(|wake_events_i) && (|status_events_i)
        |=> int_o == $past(ewk_q[EWK_INT_GLOBAL_BIT]))
        else $error("status interrupt not gated by global bit");

    bus_wake_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        bus_wake_i && in_stop |=> wdg_bus_wake_start_o == $past(wdg_q[WDG_BUS_WAKE_BIT]))
        else $error("bus wake start does not follow enable");
endmodule
`default_nettype wire

// ===== design/wbr_spi_frame.sv
`timescale 1ns/100ps
`default_nettype none
module wbr_spi_frame (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic csn_i,
    input wire logic sdi_i,
    input wire logic tx_load_i,
    input wire logic [7:0] tx_data_i,
    output logic sdo_o,
    output logic hdr_o,
    output logic frame_o,
    output logic bad_frame_o,
    output logic [6:0] addr_o,
    output logic write_o,
    output logic [7:0] wdata_o
);
    import wbr_pkg::*;

    logic sclk_q;
    logic csn_q;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;
    logic [7:0] tx_q;
    logic hdr_q;
    logic frame_q;
    logic bad_q;
    logic sdo_q;
    wire rise = sclk_i && !sclk_q && !csn_i;
    wire fall = !sclk_i && sclk_q && !csn_i;
    wire frame_end = csn_i && !csn_q;

    ////////////////////////////////////////////////////////////////////////
    // LSB first, sampled on rising clock edge
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            cnt_q <= 5'h00;
            shift_q <= 16'h0000;
            hdr_q <= 1'b0;
            frame_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
            csn_q <= csn_i;
            hdr_q <= rise && (cnt_q == HDR_LAST_C);
            frame_q <= frame_end && (cnt_q == FRAME_BITS_C);
            bad_q <= frame_end && (cnt_q != FRAME_BITS_C);
            if (csn_i) begin
                cnt_q <= 5'h00;
            end else if (rise) begin
                shift_q <= {sdi_i, shift_q[15:1]};
                // Saturate so overlong frames stay flagged as bad
                cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data bits shift out on falling edges after the header
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
        end else if (tx_load_i) begin
            tx_q <= tx_data_i;
        end else if (fall && (cnt_q >= 5'h08)) begin
            sdo_q <= tx_q[0];
            tx_q <= {1'b0, tx_q[7:1]};
        end
    end

    assign sdo_o = sdo_q;
    assign hdr_o = hdr_q;
    assign frame_o = frame_q;
    assign bad_frame_o = bad_q;
    assign addr_o = hdr_q ? shift_q[14:8] : shift_q[6:0];
    assign write_o = shift_q[7];
    assign wdata_o = shift_q[15:8];
endmodule
`default_nettype wire

// ===== inc/wbr_pkg.sv
package wbr_pkg;

    typedef enum logic [3:0] {
        WBR_MODE_INIT = 4'b0001,
        WBR_MODE_NORMAL = 4'b0010,
        WBR_MODE_STOP = 4'b0100,
        WBR_MODE_OTHER = 4'b1000
    } wbr_mode_t;

    localparam int FRAME_BITS = 16;
    localparam int HDR_BITS = 8;
    localparam logic [4:0] FRAME_BITS_C = 5'h10;
    localparam logic [4:0] HDR_LAST_C = 5'h07;

    localparam logic [6:0] ADDR_HW_CTRL = 7'h02;
    localparam logic [6:0] ADDR_WDG_SETUP = 7'h03;
    localparam logic [6:0] ADDR_TRX_MODE = 7'h04;
    localparam logic [6:0] ADDR_PEAK_TH = 7'h05;
    localparam logic [6:0] ADDR_IWAKE = 7'h06;
    localparam logic [6:0] ADDR_EWAKE = 7'h07;

    localparam logic [7:0] HW_WMASK = 8'hFB;
    localparam logic [7:0] WDG_WMASK = 8'hF7;
    localparam logic [7:0] TRX_WMASK = 8'h03;
    localparam logic [7:0] PEAK_WMASK = 8'h20;
    localparam logic [7:0] IWK_WMASK = 8'hC4;
    localparam logic [7:0] EWK_WMASK = 8'hA7;

    localparam logic [7:0] HW_RST = 8'h00;
    localparam logic [7:0] WDG_RST = 8'h14;
    localparam logic [7:0] TRX_RST = 8'h00;
    localparam logic [7:0] PEAK_RST = 8'h00;
    localparam logic [7:0] IWK_RST = 8'h00;
    localparam logic [7:0] EWK_RST = 8'h07;

    localparam logic [7:0] HW_SOFT_KEEP = 8'h88;
    localparam logic [7:0] HW_RESTART_KEEP = 8'hD9;
    localparam logic [7:0] WDG_RESTART_KEEP = 8'hB0;
    localparam logic [7:0] WDG_RESTART_SET = 8'h04;
    localparam logic [7:0] PEAK_RESTART_KEEP = 8'h20;
    localparam logic [7:0] IWK_RESTART_KEEP = 8'hC0;
    localparam logic [7:0] EWK_RESTART_KEEP = 8'hA7;
    localparam logic [7:0] EWK_FAILSAFE_SET = 8'h07;
    localparam logic [1:0] TRX_WAKE_CAPABLE = 2'h1;

    localparam int HW_VCFG_BIT = 7;
    localparam int HW_FO_BIT = 5;
    localparam int HW_LS_BIT = 3;
    localparam int HW_LS_STOP_BIT = 1;
    localparam int WDG_STOP_LO_BIT = 6;
    localparam int WDG_WIN_BIT = 5;
    localparam int WDG_BUS_WAKE_BIT = 4;
    localparam int PEAK_BIT = 5;
    localparam int IWK_TIMER_B_BIT = 7;
    localparam int IWK_TIMER_A_BIT = 6;
    localparam int IWK_STOP_HI_BIT = 2;
    localparam int EWK_INT_GLOBAL_BIT = 7;

    localparam logic [2:0] WDG_PERIOD_LAST = 3'h5;
    localparam logic [9:0] PERIOD_10_MS = 10'h00A;
    localparam logic [9:0] PERIOD_20_MS = 10'h014;
    localparam logic [9:0] PERIOD_50_MS = 10'h032;
    localparam logic [9:0] PERIOD_100_MS = 10'h064;
    localparam logic [9:0] PERIOD_200_MS = 10'h0C8;
    localparam logic [9:0] PERIOD_500_MS = 10'h1F4;

endpackage
